// ==== logic/awu_pkg.sv ====
// Package of constants shared by the auto wakeup block.
package awu_pkg;

  // ----------------------------------------------------------------
  // Register map (byte offsets on the register bus)
  // ----------------------------------------------------------------
  localparam int AWU_ADDR_W = 5;
  localparam logic [4:0] AWU_OFF_KEYPAD_STATUS_CONTROL = 5'h00;
  localparam logic [4:0] AWU_OFF_KEYPAD_IRQ_ENABLE_REG = 5'h04;
  localparam logic [4:0] AWU_OFF_CONFIG_REG_ONE = 5'h08;
  localparam logic [4:0] AWU_OFF_CONFIG_REG_TWO = 5'h0c;
  localparam logic [4:0] AWU_OFF_PORT_A_DATA = 5'h10;
  localparam logic [4:0] AWU_OFF_IRQ_STATUS = 5'h14;
  localparam logic [4:0] AWU_OFF_IRQ_MASK = 5'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int AWU_BIT_KEYPAD_ACK = 2;
  localparam int AWU_BIT_WAKE_IRQ_ENABLE = 6;
  localparam int AWU_BIT_PERIOD_SELECT = 0;
  localparam int AWU_BIT_OSC_RUN_IN_HALT_SELECT = 1;
  localparam int AWU_BIT_WAKE_LATCH = 6;
  localparam int AWU_EV_OVERFLOW = 0;
  localparam int AWU_EV_LATCH_SET = 1;
  localparam int AWU_EV_W = 2;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic AWU_RST_WAKE_IRQ_ENABLE = 1'b0;
  localparam logic AWU_RST_PERIOD_SELECT = 1'b0;
  localparam logic AWU_RST_OSC_SELECT = 1'b0;
  localparam logic [1:0] AWU_RST_IRQ = 2'h0;
  localparam int AWU_CNT_W = 16;
  localparam int AWU_SHORT_COUNT = 512;
  localparam int AWU_LONG_COUNT = 16384;

  localparam logic [1:0] AWU_RESP_OKAY = 2'h0;
  localparam logic [1:0] AWU_RESP_SLVERR = 2'h2;

  // True for an offset that holds a register.
  function automatic logic awu_mapped(input logic [4:0] a);
    return (a == AWU_OFF_KEYPAD_STATUS_CONTROL) || (a == AWU_OFF_KEYPAD_IRQ_ENABLE_REG) ||
           (a == AWU_OFF_CONFIG_REG_ONE) || (a == AWU_OFF_CONFIG_REG_TWO) ||
           (a == AWU_OFF_PORT_A_DATA) || (a == AWU_OFF_IRQ_STATUS) || (a == AWU_OFF_IRQ_MASK);
  endfunction

endpackage

// ==== logic/awu_reg_if.sv ====
// Register access carrier between the bus slave and the wakeup core.
`timescale 1ns/100ps
interface awu_reg_if;
  logic wr_req;
  logic [4:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [4:0] rd_addr;
  logic [31:0] rd_data;

  modport slave (
    output wr_req, wr_addr, wr_data, wr_strb, rd_addr,
    input rd_data
  );
  modport core (
    input wr_req, wr_addr, wr_data, wr_strb, rd_addr,
    output rd_data
  );
endinterface

// ==== logic/awu_period_counter.sv ====
// Wakeup period counter with short and long overflow counts.
`timescale 1ns/100ps
module awu_period_counter import awu_pkg::*; #(
  parameter int CNT_W = AWU_CNT_W,
  parameter int SHORT_COUNT = AWU_SHORT_COUNT,
  parameter int LONG_COUNT = AWU_LONG_COUNT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Control
  input wire logic active,
  input wire logic tick,
  input wire logic period_select,
  // Event
  output logic overflow
);

  if (SHORT_COUNT < 1 || LONG_COUNT < 1 || LONG_COUNT >= (1 << CNT_W) ||
      SHORT_COUNT >= (1 << CNT_W)) begin : g_bad_count
    $error("awu_period_counter: counts do not fit the counter");
  end

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] last;

  assign last = period_select ? CNT_W'(SHORT_COUNT - 1) : CNT_W'(LONG_COUNT - 1); // R7
  assign overflow = active && tick && (cnt_q == last); // R5

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (!active) begin
        cnt_q <= '0; // R11 R2
      end else if (overflow) begin
        cnt_q <= '0;
      end else if (tick) begin
        cnt_q <= cnt_q + CNT_W'(1);
      end
    end
  end

  a_cnt_start_zero: assert property (@(posedge clk) disable iff (!rstn)
    ce && !active |=> cnt_q == '0) // R11
    else $error("counter not cleared outside stop");
  a_ovf_wraps_zero: assert property (@(posedge clk) disable iff (!rstn)
    ce && overflow |=> cnt_q == '0 && $past(cnt_q) == $past(last)) // R7
    else $error("overflow at wrong count");

endmodule // awu_period_counter

// ==== logic/awu_axil_slave.sv ====
// AXI4-Lite slave front end for the wakeup registers.
`timescale 1ns/100ps
module awu_axil_slave import awu_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Write channels
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AWU_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // Read channels
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [AWU_ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Core side
  awu_reg_if.slave rif
);

  logic aw_full_q;
  logic w_full_q;
  logic [4:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  // Readies drop while frozen so that no beat is taken and then lost.
  assign s_axi_awready = ce && !aw_full_q && !s_axi_bvalid;
  assign s_axi_wready = ce && !w_full_q && !s_axi_bvalid;
  assign s_axi_arready = ce && !s_axi_rvalid;

  assign rif.wr_req = ce && aw_full_q && w_full_q && !s_axi_bvalid;
  assign rif.wr_addr = awaddr_q;
  assign rif.wr_data = wdata_q;
  assign rif.wr_strb = wstrb_q;
  assign rif.rd_addr = s_axi_araddr;

  // ----------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AWU_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        awaddr_q <= {s_axi_awaddr[4:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (rif.wr_req) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= awu_mapped(awaddr_q) ? AWU_RESP_OKAY : AWU_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= AWU_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rif.rd_data;
        s_axi_rresp <= awu_mapped({s_axi_araddr[4:2], 2'h0}) ? AWU_RESP_OKAY : AWU_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // awu_axil_slave

// ==== logic/awu_top.sv ====
// Auto wakeup unit: stop-mode period generator, wake latch and registers.
//
// Summary of operation
// (R1) Overflows become wakeup requests handed to the keypad interrupt unit instead of a pin event.
// (R2) Oscillator, counter and request generation stay idle in run mode and work only in stop.
// (R3) A wakeup request sets the wake latch only while the wake interrupt enable bit is set.
// (R4) The counter counts private RC oscillator edges with the select bit clear, doubled bus clock edges with it set.
// (R5) At the overflow count the latch is set and the request is forwarded to the keypad logic.
// (R6) The latched request raises the keypad-vector interrupt only while the enable bit is set.
// (R7) Period select one picks the short overflow count and zero the long one.
// (R8) The latch reads at bit 6 of the port A data register, read-only, with nothing else at that bit.
// (R9) Writing the keypad acknowledge bit clears the latch, and reset clears it too.
// (R10) Reading the latch shows its true state whatever the enable bit says.
// (R11) The counter is held at zero outside stop so each stop starts a full period.
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module awu_top import awu_pkg::*; #(
  parameter int CNT_W = AWU_CNT_W,
  parameter int SHORT_COUNT = AWU_SHORT_COUNT,
  parameter int LONG_COUNT = AWU_LONG_COUNT
) (
  // Clock, reset and freeze
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Power mode from the system logic
  input wire logic stop_mode,
  // Count sources, asynchronous to clk
  input wire logic private_rc_oscillator,
  input wire logic double_bus_clock,
  output logic rc_osc_enable,
  // Keypad interrupt unit side
  output logic wake_request,
  output logic kbi_wake_irq,
  // Interrupt
  output logic irq,
  // AXI4-Lite write channels
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AWU_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read channels
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [AWU_ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  awu_reg_if rif ();

  awu_axil_slave u_bus (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .rif(rif)
  );

  logic wake_irq_enable_q;
  logic period_select_q;
  logic osc_run_in_halt_select_q;
  logic wake_latch_q;
  logic [AWU_EV_W-1:0] irq_status_q;
  logic [AWU_EV_W-1:0] irq_mask_q;
  logic [AWU_EV_W-1:0] events;

  // Only the low byte carries fields, so only its strobe matters.
  function automatic logic wr_hit(input logic [4:0] off);
    return rif.wr_req && (rif.wr_addr == off) && rif.wr_strb[0];
  endfunction

  logic keypad_ack;
  assign keypad_ack = wr_hit(AWU_OFF_KEYPAD_STATUS_CONTROL) && rif.wr_data[AWU_BIT_KEYPAD_ACK];

  // ----------------------------------------------------------------
  // Clock source synchronisers and edge detection
  // ----------------------------------------------------------------
  // Index 0 is the private RC oscillator, index 1 the doubled bus clock.
  logic [1:0] src_pins;
  logic [1:0] src_meta_q;
  logic [1:0] src_sync_q;
  logic [1:0] src_last_q;
  logic [1:0] src_rise;
  logic tick;

  assign src_pins = {double_bus_clock, private_rc_oscillator};

  for (genvar i = 0; i < 2; i++) begin : g_src
    always_ff @(posedge clk) begin
      if (!rstn) begin
        src_meta_q[i] <= 1'b0;
        src_sync_q[i] <= 1'b0;
        src_last_q[i] <= 1'b0;
      end else if (ce) begin
        src_meta_q[i] <= src_pins[i];
        src_sync_q[i] <= src_meta_q[i];
        src_last_q[i] <= src_sync_q[i];
      end
    end
    assign src_rise[i] = src_sync_q[i] && !src_last_q[i];
  end

  // The sources must run well below clk/2 or edges are missed.
  assign tick = osc_run_in_halt_select_q ? src_rise[1] : src_rise[0]; // R4
  // The private oscillator only runs in stop and only when it is the source.
  assign rc_osc_enable = stop_mode && !osc_run_in_halt_select_q; // R2 R4

  // ----------------------------------------------------------------
  // Period counter
  // ----------------------------------------------------------------
  awu_period_counter #(
    .CNT_W(CNT_W),
    .SHORT_COUNT(SHORT_COUNT),
    .LONG_COUNT(LONG_COUNT)
  ) u_cnt (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .active(stop_mode), // R2 R11
    .tick(tick),
    .period_select(period_select_q), // R7
    .overflow(wake_request) // R1 R5
  );

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wake_irq_enable_q <= AWU_RST_WAKE_IRQ_ENABLE;
    end else if (ce && wr_hit(AWU_OFF_KEYPAD_IRQ_ENABLE_REG)) begin
      wake_irq_enable_q <= rif.wr_data[AWU_BIT_WAKE_IRQ_ENABLE];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      period_select_q <= AWU_RST_PERIOD_SELECT;
    end else if (ce && wr_hit(AWU_OFF_CONFIG_REG_ONE)) begin
      period_select_q <= rif.wr_data[AWU_BIT_PERIOD_SELECT]; // R7
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      osc_run_in_halt_select_q <= AWU_RST_OSC_SELECT;
    end else if (ce && wr_hit(AWU_OFF_CONFIG_REG_TWO)) begin
      osc_run_in_halt_select_q <= rif.wr_data[AWU_BIT_OSC_RUN_IN_HALT_SELECT]; // R4
    end
  end

  // ----------------------------------------------------------------
  // Wake latch
  // ----------------------------------------------------------------
  // A request in the acknowledge cycle wins so no wakeup is lost.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wake_latch_q <= 1'b0; // R9
    end else if (ce) begin
      if (wake_request && wake_irq_enable_q) begin
        wake_latch_q <= 1'b1; // R3 R5
      end else if (keypad_ack) begin
        wake_latch_q <= 1'b0; // R9
      end
    end
  end

  assign kbi_wake_irq = wake_latch_q && wake_irq_enable_q; // R6 R1

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  assign events[AWU_EV_OVERFLOW] = wake_request;
  assign events[AWU_EV_LATCH_SET] = wake_request && wake_irq_enable_q && !wake_latch_q;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq_status_q <= AWU_RST_IRQ;
    end else if (ce) begin
      if (wr_hit(AWU_OFF_IRQ_STATUS)) begin
        irq_status_q <= (irq_status_q & ~rif.wr_data[AWU_EV_W-1:0]) | events;
      end else begin
        irq_status_q <= irq_status_q | events;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq_mask_q <= AWU_RST_IRQ;
    end else if (ce && wr_hit(AWU_OFF_IRQ_MASK)) begin
      irq_mask_q <= rif.wr_data[AWU_EV_W-1:0];
    end
  end

  assign irq = |(irq_status_q & irq_mask_q);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // The acknowledge bit is a write strobe and always reads zero.
  always_comb begin
    rif.rd_data = 32'h0;
    unique case ({rif.rd_addr[4:2], 2'h0})
      AWU_OFF_KEYPAD_IRQ_ENABLE_REG: rif.rd_data[AWU_BIT_WAKE_IRQ_ENABLE] = wake_irq_enable_q;
      AWU_OFF_CONFIG_REG_ONE: rif.rd_data[AWU_BIT_PERIOD_SELECT] = period_select_q;
      AWU_OFF_CONFIG_REG_TWO: begin
        rif.rd_data[AWU_BIT_OSC_RUN_IN_HALT_SELECT] = osc_run_in_halt_select_q;
      end
      AWU_OFF_PORT_A_DATA: rif.rd_data[AWU_BIT_WAKE_LATCH] = wake_latch_q; // R8 R10
      AWU_OFF_IRQ_STATUS: rif.rd_data[AWU_EV_W-1:0] = irq_status_q;
      AWU_OFF_IRQ_MASK: rif.rd_data[AWU_EV_W-1:0] = irq_mask_q;
      default: rif.rd_data = 32'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_latch_set_req: assert property (@(posedge clk) disable iff (!rstn) // R3
    ce && wake_request && wake_irq_enable_q |=> wake_latch_q)
    else $error("enabled request did not set the latch");

  a_latch_set_cause: assert property (@(posedge clk) disable iff (!rstn) // R5
    $rose(wake_latch_q) |-> $past(wake_request) && $past(wake_irq_enable_q))
    else $error("latch set without an enabled request");

  a_ack_clears_latch: assert property (@(posedge clk) disable iff (!rstn) // R9
    ce && keypad_ack && !(wake_request && wake_irq_enable_q) |=> !wake_latch_q)
    else $error("acknowledge did not clear the latch");

  a_kbi_irq_gated: assert property (@(posedge clk) disable iff (!rstn) // R6
    wake_latch_q && !wake_irq_enable_q |-> !kbi_wake_irq)
    else $error("wake interrupt raised while disabled");

  a_run_mode_quiet: assert property (@(posedge clk) disable iff (!rstn) // R2
    !stop_mode |-> !wake_request && !rc_osc_enable)
    else $error("wakeup logic active in run mode");

  a_tick_source_sel: assert property (@(posedge clk) disable iff (!rstn) // R4
    wake_request |-> (osc_run_in_halt_select_q ? src_rise[1] : src_rise[0]))
    else $error("request without an edge of the selected source");

  a_porta_latch_read: assert property (@(posedge clk) disable iff (!rstn) // R8
    s_axi_arvalid && s_axi_arready && s_axi_araddr == AWU_OFF_PORT_A_DATA
    |=> s_axi_rdata == {25'h0, $past(wake_latch_q), 6'h0})
    else $error("port A read does not show the latch alone");

  a_latch_read_true: assert property (@(posedge clk) disable iff (!rstn) // R10
    s_axi_arvalid && s_axi_arready && s_axi_araddr == AWU_OFF_PORT_A_DATA && !wake_irq_enable_q
    ##1 s_axi_rvalid |-> s_axi_rdata[AWU_BIT_WAKE_LATCH] == $past(wake_latch_q))
    else $error("latch read masked by the enable bit");

  // Freeze checks only fire while the bench pulls ce low inside a stop window.
  a_freeze_holds: assert property (@(posedge clk) disable iff (!rstn)
    !ce |=> $stable(wake_latch_q) && $stable(irq_status_q) && $stable(irq_mask_q))
    else $error("state changed while frozen");

  a_latch_fall_ack: assert property (@(posedge clk) disable iff (!rstn) // R9
    $fell(wake_latch_q) |-> $past(keypad_ack))
    else $error("latch cleared without an acknowledge");

  a_latch_held: assert property (@(posedge clk) disable iff (!rstn) // R9
    wake_latch_q && !keypad_ack |=> wake_latch_q)
    else $error("latch dropped without an acknowledge");

  a_status_sticky: assert property (@(posedge clk) disable iff (!rstn)
    !(rif.wr_req && rif.wr_addr == AWU_OFF_IRQ_STATUS && rif.wr_strb[0])
    |=> (irq_status_q & $past(irq_status_q)) == $past(irq_status_q))
    else $error("status bit cleared without a write");

  a_status_ovf_set: assert property (@(posedge clk) disable iff (!rstn) // R5
    ce && wake_request |=> irq_status_q[AWU_EV_OVERFLOW])
    else $error("overflow did not set its status bit");

  a_mask_write: assert property (@(posedge clk) disable iff (!rstn)
    rif.wr_req && rif.wr_addr == AWU_OFF_IRQ_MASK && rif.wr_strb[0]
    |=> irq_mask_q == $past(rif.wr_data[AWU_EV_W-1:0]))
    else $error("mask write did not land");

endmodule // awu_top

// ==== tb/awu_keypad_partner.sv ====
// Far-side model: the two count sources and the keypad-side request counter.
`timescale 1ns/100ps
module awu_keypad_partner (
  // Clock
  input wire logic clk,
  // Count sources
  input wire logic rc_osc_enable,
  output logic private_rc_oscillator,
  output logic double_bus_clock,
  // Keypad side
  input wire logic wake_request,
  output int req_count
);
  // The RC source stands still while disabled, so no stray edge can reach the counter.
  initial begin
    private_rc_oscillator = 1'b0;
    #3;
    forever begin
      #36;
      private_rc_oscillator = rc_osc_enable ? !private_rc_oscillator : 1'b0;
    end
  end
  initial begin
    double_bus_clock = 1'b0;
    #1;
    forever #28 double_bus_clock = !double_bus_clock;
  end
  initial req_count = 0;
  always @(posedge clk) begin
    if (wake_request === 1'b1) req_count <= req_count + 1;
  end
endmodule // awu_keypad_partner

// ==== tb/auto_wakeup_timer_bench.sv ====
// Self-checking bench for the auto wakeup unit.
`timescale 1ns/100ps
module auto_wakeup_timer_bench import awu_pkg::*;;
  localparam int SC = 4;
  localparam int LC = 8;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic stop = 1'b0;
  logic ce = 1'b1;
  logic awv = 1'b0, wv = 1'b0, arv = 1'b0, brdy = 1'b0, rrdy = 1'b0;
  logic [4:0] awa = 5'h00, ara = 5'h00;
  logic [31:0] wd = 32'h0;
  logic [3:0] st = 4'hf;
  logic awr, wrd, bv, arr, rv, rc, bc, rce, wreq, kirq, irq;
  logic [1:0] br, rr;
  logic [31:0] rdat;
  logic [31:0] seed = 32'h0001509b;
  int failures = 0, samples_checked = 0, cyc = 0, nreq = 0, preq;
  int m_en, m_ps, m_os, m_lat, m_stat, m_mask;

  always #4 clk = !clk;

  awu_top #(.SHORT_COUNT(SC), .LONG_COUNT(LC)) u_dut (
    .clk(clk), .rstn(rstn), .ce(ce), .stop_mode(stop),
    .private_rc_oscillator(rc), .double_bus_clock(bc), .rc_osc_enable(rce),
    .wake_request(wreq), .kbi_wake_irq(kirq), .irq(irq),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd), .s_axi_wstrb(st),
    .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_bresp(br),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
    .s_axi_rvalid(rv), .s_axi_rready(rrdy), .s_axi_rdata(rdat), .s_axi_rresp(rr));

  awu_keypad_partner u_kp (.clk(clk), .rc_osc_enable(rce), .private_rc_oscillator(rc),
    .double_bus_clock(bc), .wake_request(wreq), .req_count(preq));

  // ----------------------------------------------------------------
  // Compare, bus and model tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] exp_rd(input logic [4:0] a);
    case (a)
      AWU_OFF_KEYPAD_IRQ_ENABLE_REG: return 32'(m_en) << 6;
      AWU_OFF_CONFIG_REG_ONE: return 32'(m_ps);
      AWU_OFF_CONFIG_REG_TWO: return 32'(m_os) << 1;
      AWU_OFF_PORT_A_DATA: return 32'(m_lat) << 6;
      AWU_OFF_IRQ_STATUS: return 32'(m_stat);
      AWU_OFF_IRQ_MASK: return 32'(m_mask);
      default: return 32'h0;
    endcase
  endfunction

  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_time(input int g, input int lo, input int hi);
    samples_checked++;
    if (g < lo || g > hi) begin
      failures++;
      $display("mismatch at %0t got %h expected %h to %h", $time, g, lo, hi);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ga, gw;
    ga = 0;
    gw = 0;
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= d;
    while (!(ga && gw)) begin
      @(posedge clk);
      if (!ga && awr === 1'b1) begin
        ga = 1;
        awv <= 1'b0;
      end
      if (!gw && wrd === 1'b1) begin
        gw = 1;
        wv <= 1'b0;
      end
    end
    brdy <= 1'b1;
    do @(posedge clk); while (bv !== 1'b1);
    brdy <= 1'b0;
    chk_word(32'(br), 32'(er));
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] d, input logic [1:0] er);
    arv <= 1'b1;
    ara <= a;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    rrdy <= 1'b1;
    do @(posedge clk); while (rv !== 1'b1);
    d = rdat;
    rrdy <= 1'b0;
    chk_word(32'(rr), 32'(er));
  endtask

  // Random upper bytes prove that only byte 0 carries fields.
  task automatic setr(input logic [4:0] a, input logic [7:0] v);
    logic [31:0] d;
    d = rnd();
    d[7:0] = v;
    wr(a, d, AWU_RESP_OKAY);
  endtask

  task automatic check_regs();
    logic [31:0] d;
    for (int i = 0; i < 8; i++) begin
      rd(5'(i * 4), d, (i == 7) ? AWU_RESP_SLVERR : AWU_RESP_OKAY);
      chk_word(d, exp_rd(5'(i * 4)));
    end
    chk_word(32'(kirq), 32'(m_lat & m_en));
    chk_word(32'(irq), 32'((m_stat & m_mask) != 0));
  endtask

  task automatic wait_req(output int t);
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (wreq !== 1'b1);
    nreq++;
    m_stat |= 1;
    if (m_en != 0 && m_lat == 0) m_stat |= 2;
    if (m_en != 0) m_lat = 1;
  endtask

  task automatic stop_run(input int ps, input int os);
    int t, n, p;
    n = ps ? SC : LC;
    p = os ? 7 : 9;
    stop <= 1'b1;
    repeat (2) @(posedge clk);
    chk_word(32'(rce), 32'(!os));
    wait_req(t);
    chk_time(t, (n - 1) * p - 1, n * p + 14);
    wait_req(t);
    chk_time(t, n * p, n * p);
    stop <= 1'b0;
    @(posedge clk);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {m_en, m_ps, m_os, m_lat, m_stat, m_mask} = '0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    check_regs();
    wr(5'h1c, 32'hffffffff, AWU_RESP_SLVERR);
    setr(AWU_OFF_IRQ_MASK, 8'h03);
    m_mask = 3;
    setr(AWU_OFF_KEYPAD_IRQ_ENABLE_REG, 8'h40);
    m_en = 1;
    repeat (200) @(posedge clk);
    chk_word(32'(preq), 32'h0);
    chk_word(32'(rce), 32'h0);
    for (int i = 0; i < 4; i++) begin
      m_ps = i % 2;
      m_os = i / 2;
      setr(AWU_OFF_CONFIG_REG_ONE, 8'(m_ps));
      setr(AWU_OFF_CONFIG_REG_TWO, 8'(m_os * 2));
      stop_run(m_ps, m_os);
      check_regs();
      wr(AWU_OFF_PORT_A_DATA, 32'hffffffff, AWU_RESP_OKAY);
      wr(AWU_OFF_KEYPAD_STATUS_CONTROL, 32'h4, AWU_RESP_OKAY);
      m_lat = 0;
      wr(AWU_OFF_IRQ_STATUS, 32'h3, AWU_RESP_OKAY);
      m_stat = 0;
      check_regs();
    end
    setr(AWU_OFF_KEYPAD_IRQ_ENABLE_REG, 8'h00);
    m_en = 0;
    stop_run(1, 1);
    check_regs();
    setr(AWU_OFF_IRQ_MASK, 8'h02);
    m_mask = 2;
    st <= 4'he;
    setr(AWU_OFF_KEYPAD_IRQ_ENABLE_REG, 8'h40);
    st <= 4'hf;
    check_regs();
    stop <= 1'b1;
    repeat (4) @(posedge clk);
    ce <= 1'b0;
    repeat (4) @(posedge clk);
    ce <= 1'b1;
    repeat (2 + rnd() % 8) @(posedge clk);
    stop <= 1'b0;
    repeat (3) @(posedge clk);
    chk_word(32'(preq), 32'(nreq));
    stop_run(1, 1);
    setr(AWU_OFF_KEYPAD_IRQ_ENABLE_REG, 8'h40);
    m_en = 1;
    stop_run(1, 1);
    setr(AWU_OFF_KEYPAD_IRQ_ENABLE_REG, 8'h00);
    m_en = 0;
    check_regs();
    rstn <= 1'b0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    {m_en, m_ps, m_os, m_lat, m_stat, m_mask} = '0;
    check_regs();
    chk_word(32'(preq), 32'(nreq));
    tally_and_finish();
  end
endmodule // auto_wakeup_timer_bench
